/* logic/msc_pkg.sv */
// shared constants and types for the sample and convert sequencer
package msc_pkg;

	// register byte offsets
	localparam logic [7:0] CTRL_OFS  = 8'h00;
	localparam logic [7:0] MUX_OFS   = 8'h04;
	localparam logic [7:0] SCAN_OFS  = 8'h08;
	localparam logic [7:0] STAT_OFS  = 8'h0C;
	localparam logic [7:0] BUF_OFS   = 8'h40;
	localparam logic [7:0] BUF_LAST  = 8'h7C;

	// reset values and writable bits
	localparam logic [15:0] CTRL_RST   = 16'h0000;
	localparam logic [15:0] CTRL_WMASK = 16'hF37F;
	localparam logic [15:0] MUX_RST    = 16'h0000;
	localparam logic [15:0] SCAN_RST   = 16'h0000;
	localparam logic [3:0]  SCAN_START = 4'hF;

	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// negative input codes driven to the hold stages
	localparam logic [1:0] NEG_GND = 2'h0;
	localparam logic [1:0] NEG_AN1 = 2'h1;
	localparam logic [1:0] NEG_ALT = 2'h2;

	// first analog input routed to channel 1 for each shared select value
	localparam logic [3:0] CH13_LOW_BASE  = 4'h0;
	localparam logic [3:0] CH13_HIGH_BASE = 4'h3;

	// channel enable masks per channel count select
	localparam logic [3:0] EN_ONE  = 4'h1;
	localparam logic [3:0] EN_TWO  = 4'h3;
	localparam logic [3:0] EN_FOUR = 4'hF;

	// least sampling time per channel
	localparam int         SAMPLE_TIME_NS = 1000;
	localparam int         CLK_PERIOD_NS  = 40;
	localparam int         SAMPLE_CYC_INT = (SAMPLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [4:0] SAMPLE_CNT     = 5'(SAMPLE_CYC_INT);

	typedef struct packed {
		logic [3:0] samples_per_interrupt;
		logic [1:0] zero_hi;
		logic [1:0] channel_count_select;
		logic       zero_lo;
		logic       input_scan_enable;
		logic       alternate_input_enable;
		logic       buffer_split_select;
		logic       simultaneous_sample_select;
		logic       manual_sample_request;
		logic       auto_sample_enable;
		logic       converter_enable;
	} msc_ctrl_t;

	typedef struct packed {
		logic [1:0] ch1to3_neg_select;
		logic       ch1to3_pos_select;
		logic       ch0_neg_select;
		logic [3:0] ch0_pos_select;
	} msc_mux_t;

	typedef struct packed {
		logic [13:0] zero;
		logic [3:0]  held;
		logic [3:0]  sampling;
		logic        busy;
		logic        upper_half;
		logic [3:0]  sample_count;
		logic [3:0]  write_ptr;
	} msc_stat_t;

	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} msc_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} msc_axi_rsp_t;

	typedef enum logic [1:0] {SEQ_IDLE, SEQ_WAIT, SEQ_CONV} msc_state_t;
	typedef enum logic [2:0] {REG_CTRL, REG_MUX, REG_SCAN, REG_STAT, REG_BUF, REG_NONE} msc_reg_t;

endpackage : msc_pkg

/* logic/msc_sh_chan.sv */
// one sample-and-hold channel: sampling timer, hold flag and input set
`timescale 1ns/1ns
`default_nettype none
module msc_sh_chan (
	input  wire logic mclk,
	input  wire logic reset,
	input  wire logic abort,
	input  wire logic start,
	input  wire logic hold,
	input  wire logic done,
	input  wire logic flip,
	input  wire logic to_a,
	output var  logic sampling,
	output wire logic ready,
	output var  logic held,
	output var  logic set_b
);
	import msc_pkg::*;

	logic [4:0] cnt;

	assign ready = sampling && (cnt == SAMPLE_CNT);

	always_ff @(posedge mclk) begin
		if (reset || abort) begin
			sampling <= 1'b0;
			held     <= 1'b0;
			cnt      <= 5'h00;
		end else if (start) begin
			sampling <= 1'b1;
			cnt      <= 5'h00;
		end else if (hold) begin
			sampling <= 1'b0;
			held     <= 1'b1;
		end else if (done) begin
			held <= 1'b0;
		end else if (sampling && !ready) begin
			cnt <= cnt + 5'h01;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset || abort || to_a)
			set_b <= 1'b0;
		else if (flip)
			set_b <= ~set_b;
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (reset);

	full_sample_a: assert property ($rose(held) |-> $past(cnt) == SAMPLE_CNT)
		else $error("channel held before its sampling time");

endmodule : msc_sh_chan
`default_nettype wire

/* logic/msc_sequencer.sv */
// sample and convert sequencer for four hold channels with register bus
//
// Function
// - sequential mode starts each channel sampling early, converts channels in turn
// - with auto sampling and simultaneous select low, a channel resamples once its own conversion ends
// - without auto sampling, sampling starts only on the manual request bit
// - one channel may sample while another converts
// - interrupt after samples-per-interrupt plus one conversions; 1111 gives sixteen
// - channel count field with upper bit set enables all four channels
// - simultaneous select low samples the channels one after another
// - buffer split low uses one sixteen-word result buffer
// - alternate input on swaps input sets A and B on successive passes
// - channel 0 positive input equals the four-bit select value
// - channel 0 negative select high connects analog input 1
// - shared positive select low routes inputs 0,1,2 to channels 1,2,3
// - shared positive select high routes inputs 3,4,5 to channels 1,2,3
// - shared negative field 0x ties channels 1 to 3 to analog ground
// - scan disabled ignores the scan mask for channel 0 input
// - with buffer split low each result goes to the next word 0 up to samples-per-interrupt, then interrupt, repeat
// - a channel finishes its sampling time before its conversion starts
// - simultaneous select high samples all channels together, converts in turn
`timescale 1ns/1ns
`default_nettype none
module msc_sequencer (
	input  wire logic                  mclk,
	input  wire logic                  reset,
	input  wire msc_pkg::msc_axi_req_t axi_req,
	output wire msc_pkg::msc_axi_rsp_t axi_rsp,
	input  wire logic                  conv_done,
	input  wire logic [9:0]            conv_result,
	output var  logic                  conv_start,
	output var  logic [1:0]            conv_channel,
	output wire logic [3:0]            sh_sample,
	output var  logic [3:0]            sh_pos_input [4],
	output var  logic [1:0]            sh_neg_input [4],
	output var  logic                  samples_done
);
	import msc_pkg::*;

	msc_ctrl_t  ctrl;
	msc_mux_t   input_select_set_a;
	msc_mux_t   input_select_set_b;
	logic [15:0] scan_input_mask;
	msc_state_t state;
	logic [1:0] cur;
	logic [1:0] last_ch;
	logic [3:0] wr_ptr;
	logic [3:0] smp_cnt;
	logic       upper_half;
	logic [9:0] result_buf [16];
	logic [3:0] scan_ptr;
	logic [3:0] scan_pick;
	logic [3:0] en_mask;
	logic [3:0] start;
	logic [3:0] hold;
	logic [3:0] done_ch;
	logic [3:0] sampling;
	logic [3:0] ready;
	logic [3:0] held;
	logic [3:0] set_b;
	logic       trig;
	logic       go;
	logic       conv_go;
	logic       done_evt;
	logic       last_evt;
	msc_stat_t  stat;

	// bus side flops
	logic        awready_q;
	logic        wready_q;
	logic        aw_have;
	logic        w_have;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        arready_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	logic [31:0] rd_data;
	logic        rd_ok;
	logic        do_write;
	msc_reg_t    wr_reg;
	msc_reg_t    rd_reg;

	function automatic msc_reg_t decode(input logic [7:0] a);
		if (a == CTRL_OFS)
			return REG_CTRL;
		else if (a == MUX_OFS)
			return REG_MUX;
		else if (a == SCAN_OFS)
			return REG_SCAN;
		else if (a == STAT_OFS)
			return REG_STAT;
		else if (a >= BUF_OFS && a <= BUF_LAST && a[1:0] == 2'h0)
			return REG_BUF;
		else
			return REG_NONE;
	endfunction : decode

	function automatic logic [15:0] apply_strb(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : apply_strb

	function automatic logic [3:0] next_scan(input logic [15:0] m, input logic [3:0] p);
		logic [3:0] res;
		logic       found;
		logic [3:0] idx;
		res   = p;
		found = 1'b0;
		for (int i = 1; i <= 16; i++) begin
			idx = 4'(p + 4'(i));
			if (m[idx] && !found) begin
				res   = idx;
				found = 1'b1;
			end
		end
		return res;
	endfunction : next_scan

	function automatic logic [3:0] pos_of(input int k, input msc_mux_t m, input logic scan_on,
		input logic [3:0] pick);
		if (k == 0)
			return scan_on ? pick : m.ch0_pos_select;
		else
			return (m.ch1to3_pos_select ? CH13_HIGH_BASE : CH13_LOW_BASE) + 4'(k - 1);
	endfunction : pos_of

	function automatic logic [1:0] neg_of(input int k, input msc_mux_t m);
		if (k == 0)
			return m.ch0_neg_select ? NEG_AN1 : NEG_GND;
		else
			return m.ch1to3_neg_select[1] ? NEG_ALT : NEG_GND;
	endfunction : neg_of

	// write channel
	assign wr_reg   = decode(awaddr_q);
	assign do_write = aw_have && w_have && !bvalid_q;

	always_ff @(posedge mclk) begin
		if (reset) begin
			awready_q <= 1'b1;
			aw_have   <= 1'b0;
			awaddr_q  <= 8'h00;
		end else if (axi_req.awvalid && awready_q) begin
			awready_q <= 1'b0;
			aw_have   <= 1'b1;
			awaddr_q  <= axi_req.awaddr;
		end else if (bvalid_q && axi_req.bready) begin
			awready_q <= 1'b1;
			aw_have   <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			wready_q <= 1'b1;
			w_have   <= 1'b0;
			wdata_q  <= 32'h0000_0000;
			wstrb_q  <= 4'h0;
		end else if (axi_req.wvalid && wready_q) begin
			wready_q <= 1'b0;
			w_have   <= 1'b1;
			wdata_q  <= axi_req.wdata;
			wstrb_q  <= axi_req.wstrb;
		end else if (bvalid_q && axi_req.bready) begin
			wready_q <= 1'b1;
			w_have   <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			bresp_q  <= (wr_reg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (axi_req.bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// read channel
	assign rd_reg = decode(axi_req.araddr);

	always_comb begin
		rd_data = 32'h0000_0000;
		rd_ok   = 1'b1;
		case (rd_reg)
			REG_CTRL: rd_data = {16'h0000, ctrl};
			REG_MUX:  rd_data = {16'h0000, input_select_set_b, input_select_set_a};
			REG_SCAN: rd_data = {16'h0000, scan_input_mask};
			REG_STAT: rd_data = stat;
			REG_BUF:  rd_data = {22'h000000, result_buf[axi_req.araddr[5:2]]};
			default:  rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= RESP_OKAY;
		end else if (axi_req.arvalid && arready_q) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b1;
			rdata_q   <= rd_data;
			rresp_q   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_q && axi_req.rready) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
		end
	end

	assign axi_rsp = '{awready: awready_q, wready: wready_q, bvalid: bvalid_q, bresp: bresp_q,
		arready: arready_q, rvalid: rvalid_q, rdata: rdata_q, rresp: rresp_q};

	assign stat = '{zero: 14'h0000, held: held, sampling: sampling, busy: state != SEQ_IDLE,
		upper_half: upper_half, sample_count: smp_cnt, write_ptr: wr_ptr};

	// software registers; hardware clear of the request loses to a write of one
	always_ff @(posedge mclk) begin
		if (reset) begin
			ctrl <= msc_ctrl_t'(CTRL_RST);
		end else begin
			if (|start && !ctrl.auto_sample_enable)
				ctrl.manual_sample_request <= 1'b0;
			if (do_write && wr_reg == REG_CTRL)
				ctrl <= msc_ctrl_t'(apply_strb(ctrl, wdata_q, wstrb_q) & CTRL_WMASK);
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			{input_select_set_b, input_select_set_a} <= MUX_RST;
			scan_input_mask                         <= SCAN_RST;
		end else if (do_write && wr_reg == REG_MUX) begin
			{input_select_set_b, input_select_set_a} <=
				apply_strb({input_select_set_b, input_select_set_a}, wdata_q, wstrb_q);
		end else if (do_write && wr_reg == REG_SCAN) begin
			scan_input_mask <= apply_strb(scan_input_mask, wdata_q, wstrb_q);
		end
	end

	// channel enables
	always_comb begin
		case (ctrl.channel_count_select)
			2'b00: begin
				en_mask = EN_ONE;
				last_ch = 2'h0;
			end
			2'b01: begin
				en_mask = EN_TWO;
				last_ch = 2'h1;
			end
			default: begin
				en_mask = EN_FOUR;
				last_ch = 2'h3;
			end
		endcase
	end

	// sampling starts and holds
	always_comb begin
		trig = ctrl.converter_enable && (ctrl.auto_sample_enable || ctrl.manual_sample_request);
		if (ctrl.simultaneous_sample_select)
			start = (trig && ((~sampling & ~held & en_mask) == en_mask)) ? en_mask : 4'h0;
		else
			start = trig ? (~sampling & ~held & en_mask) : 4'h0;
		if (ctrl.simultaneous_sample_select)
			go = ((ready & en_mask) == en_mask);
		else
			go = ready[cur];
		hold = 4'h0;
		if (state == SEQ_WAIT && go && !held[cur])
			hold = ctrl.simultaneous_sample_select ? en_mask : (4'h1 << cur);
		conv_go  = state == SEQ_WAIT && (held[cur] || go);
		done_evt = state == SEQ_CONV && conv_done;
		done_ch  = done_evt ? (4'h1 << cur) : 4'h0;
		last_evt = done_evt && smp_cnt == ctrl.samples_per_interrupt;
	end

	assign scan_pick = next_scan(scan_input_mask, scan_ptr);
	assign sh_sample = sampling;

	for (genvar k = 0; k < 4; k++) begin : g_chan
		msc_sh_chan u_chan (
			.mclk     (mclk),
			.reset    (reset),
			.abort    (!ctrl.converter_enable),
			.start    (start[k]),
			.hold     (hold[k]),
			.done     (done_ch[k]),
			.flip     (done_ch[k] && ctrl.alternate_input_enable),
			.to_a     (last_evt),
			.sampling (sampling[k]),
			.ready    (ready[k]),
			.held     (held[k]),
			.set_b    (set_b[k])
		);

		always_ff @(posedge mclk) begin
			if (reset) begin
				sh_pos_input[k] <= 4'h0;
				sh_neg_input[k] <= NEG_GND;
			end else if (start[k]) begin
				sh_pos_input[k] <= pos_of(k, set_b[k] ? input_select_set_b : input_select_set_a,
					ctrl.input_scan_enable, scan_pick);
				sh_neg_input[k] <= neg_of(k, set_b[k] ? input_select_set_b : input_select_set_a);
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset)
			scan_ptr <= SCAN_START;
		else if (start[0] && ctrl.input_scan_enable)
			scan_ptr <= scan_pick;
	end

	// conversion order
	always_ff @(posedge mclk) begin
		conv_start <= 1'b0;
		if (reset || !ctrl.converter_enable) begin
			state        <= SEQ_IDLE;
			cur          <= 2'h0;
			conv_channel <= 2'h0;
		end else begin
			case (state)
				SEQ_IDLE: begin
					state <= SEQ_WAIT;
					cur   <= 2'h0;
				end
				SEQ_WAIT: begin
					if (conv_go) begin
						conv_start   <= 1'b1;
						conv_channel <= cur;
						state        <= SEQ_CONV;
					end
				end
				default: begin
					if (conv_done) begin
						cur   <= (cur == last_ch) ? 2'h0 : cur + 2'h1;
						state <= SEQ_WAIT;
					end
				end
			endcase
		end
	end

	// result placement and interrupt count
	always_ff @(posedge mclk) begin
		samples_done <= 1'b0;
		if (reset || !ctrl.converter_enable) begin
			wr_ptr     <= 4'h0;
			smp_cnt    <= 4'h0;
			upper_half <= 1'b0;
		end else if (last_evt) begin
			samples_done <= 1'b1;
			smp_cnt      <= 4'h0;
			if (ctrl.buffer_split_select) begin
				upper_half <= !upper_half;
				wr_ptr     <= {!upper_half, 3'h0};
			end else begin
				upper_half <= 1'b0;
				wr_ptr     <= 4'h0;
			end
		end else if (done_evt) begin
			smp_cnt <= smp_cnt + 4'h1;
			if (ctrl.buffer_split_select)
				wr_ptr <= {upper_half, wr_ptr[2:0] + 3'h1};
			else
				wr_ptr <= wr_ptr + 4'h1;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			for (int i = 0; i < 16; i++)
				result_buf[i] <= 10'h000;
		end else if (done_evt) begin
			result_buf[wr_ptr] <= conv_result;
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (reset);

	sequence ch0_done_s;
		state == SEQ_CONV && conv_done && cur == 2'h0;
	endsequence

	sequence auto_seq_s;
		ctrl.auto_sample_enable && !ctrl.simultaneous_sample_select && ctrl.converter_enable;
	endsequence

	conv_after_hold_a: assert property (conv_start |-> held[conv_channel] && !sampling[conv_channel])
		else $error("conversion started on a channel still sampling");
	auto_restart_a: assert property (ch0_done_s ##0 auto_seq_s |=> ctrl.converter_enable [*1] ##1 sampling[0])
		else $error("channel 0 did not resample after its conversion");
	manual_only_a: assert property (!ctrl.auto_sample_enable && !ctrl.manual_sample_request |-> start == 4'h0)
		else $error("sampling started without a request");
	sim_together_a: assert property (ctrl.simultaneous_sample_select |-> start == 4'h0 || start == en_mask)
		else $error("simultaneous start missed a channel");
	four_chan_a: assert property (ctrl.channel_count_select[1] |-> en_mask == 4'hF)
		else $error("upper count bit did not enable four channels");
	irq_count_a: assert property (samples_done |-> $past(smp_cnt) == $past(ctrl.samples_per_interrupt) && smp_cnt == 4'h0)
		else $error("interrupt at wrong conversion count");
	ptr_step_a: assert property (done_evt && !last_evt && !ctrl.buffer_split_select |=> wr_ptr == $past(wr_ptr) + 4'h1)
		else $error("result pointer did not advance");
	ptr_home_a: assert property (last_evt && !ctrl.buffer_split_select |=> wr_ptr == 4'h0 && set_b == 4'h0)
		else $error("pointer or input set not returned after interrupt");
	ch1_route_a: assert property (start[1] |=> sh_pos_input[1] == ($past(set_b[1]) ? (input_select_set_b.ch1to3_pos_select ? 4'h3 : 4'h0) : (input_select_set_a.ch1to3_pos_select ? 4'h3 : 4'h0)) + 4'h0)
		else $error("channel 1 routed to wrong input");
	ch0_neg_a: assert property (start[0] && !set_b[0] && input_select_set_a.ch0_neg_select |=> sh_neg_input[0] == NEG_AN1)
		else $error("channel 0 negative input not analog input 1");

endmodule : msc_sequencer
`default_nettype wire

/* tb/msc_conv_model.sv */
// converter core model answering conversion starts with an input-coded result
`timescale 1ns/1ns
`default_nettype none
module msc_conv_model (
	input  wire logic       mclk,
	input  wire logic       reset,
	input  wire logic       slow,
	input  wire logic       conv_start,
	input  wire logic [1:0] conv_channel,
	input  wire logic [3:0] sh_pos_input [4],
	input  wire logic [1:0] sh_neg_input [4],
	output var  logic       conv_done,
	output wire logic [9:0] conv_result
);
	logic       busy;
	logic [3:0] wait_cnt;
	logic [9:0] code;
	// result encodes the channel and the inputs it held
	always_ff @(posedge mclk) begin
		conv_done <= 1'b0;
		if (reset) begin
			busy     <= 1'b0;
			wait_cnt <= 4'h0;
			code     <= 10'h000;
		end else if (conv_start) begin
			busy     <= 1'b1;
			wait_cnt <= slow ? 4'hB : 4'h1;
			code     <= {2'h0, sh_neg_input[conv_channel], sh_pos_input[conv_channel], conv_channel};
		end else if (busy && wait_cnt == 4'h0) begin
			busy      <= 1'b0;
			conv_done <= 1'b1;
		end else if (busy) begin
			wait_cnt <= wait_cnt - 4'h1;
		end
	end
	// result bus not held outside the done cycle
	assign conv_result = conv_done ? code : ~code;
endmodule : msc_conv_model
`default_nettype wire

/* tb/multi_channel_sample_convert_sequencer_tb.sv */
// self-checking bench for the sample and convert sequencer
`timescale 1ns/1ns
`default_nettype none
module multi_channel_sample_convert_sequencer_tb;
	import msc_pkg::*;
	logic         mclk, reset, slow, conv_done, conv_start, samples_done, cbusy, overlap;
	logic [9:0]   conv_result;
	logic [1:0]   conv_channel, r;
	logic [3:0]   sh_sample, prev_s;
	logic [3:0]   sh_pos_input [4];
	logic [1:0]   sh_neg_input [4];
	logic [9:0]   scnt [4];
	logic [31:0]  d;
	msc_axi_req_t req;
	msc_axi_rsp_t rsp;
	int           n_errors, samples_checked, n_done, base;

	msc_sequencer uut (.mclk(mclk), .reset(reset), .axi_req(req), .axi_rsp(rsp),
		.conv_done(conv_done), .conv_result(conv_result), .conv_start(conv_start),
		.conv_channel(conv_channel), .sh_sample(sh_sample), .sh_pos_input(sh_pos_input),
		.sh_neg_input(sh_neg_input), .samples_done(samples_done));
	msc_conv_model core (.mclk(mclk), .reset(reset), .slow(slow), .conv_start(conv_start),
		.conv_channel(conv_channel), .sh_pos_input(sh_pos_input),
		.sh_neg_input(sh_neg_input), .conv_done(conv_done), .conv_result(conv_result));

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	task automatic finish_test;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : finish_test

	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR at %0t: value got %h expected %h", $time, got, exp);
		end
	endtask : chk_val

	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR at %0t: response got %h expected %h", $time, got, exp);
		end
	endtask : chk_resp

	task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rs);
		logic done;
		@(posedge mclk);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		done = 1'b0;
		while (!done) begin
			@(posedge mclk);
			if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
			if (rsp.rvalid === 1'b1) begin
				dat = rsp.rdata;
				rs = rsp.rresp;
				req.rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [31:0] dat);
		logic aw, w, done;
		@(posedge mclk);
		req.awaddr <= a;
		req.wdata <= dat;
		req.wstrb <= 4'hF;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		aw = 1'b0;
		w = 1'b0;
		done = 1'b0;
		while (!done) begin
			@(posedge mclk);
			if (!aw && rsp.awready === 1'b1) begin
				aw = 1'b1;
				req.awvalid <= 1'b0;
			end
			if (!w && rsp.wready === 1'b1) begin
				w = 1'b1;
				req.wvalid <= 1'b0;
			end
			if (aw && w && rsp.bvalid === 1'b1) begin
				chk_resp(rsp.bresp, RESP_OKAY);
				req.bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : wr

	task automatic do_reset;
		reset <= 1'b1;
		repeat (8) @(posedge mclk);
		reset <= 1'b0;
		wr(MUX_OFS, 32'h0000_3210);
		base = n_done;
		overlap = 1'b0;
	endtask : do_reset

	function automatic logic [31:0] exp_res(input int ch, input logic b);
		logic [3:0] p;
		logic [1:0] n;
		p = (ch == 0) ? (b ? 4'h2 : 4'h0) : (b ? CH13_HIGH_BASE : CH13_LOW_BASE) + 4'(ch - 1);
		n = (ch == 0) ? NEG_AN1 : NEG_GND;
		return {22'h0, 2'h0, n, p, 2'(ch)};
	endfunction : exp_res

	task automatic wait_start;
		do @(negedge mclk); while (conv_start !== 1'b1);
		chk_val(32'(sh_sample[conv_channel]), 32'h0);
	endtask : wait_start

	task automatic wait_done(input int n);
		do @(negedge mclk); while (samples_done !== 1'b1);
		chk_val(n_done - base, n);
	endtask : wait_done

	task automatic test_regs;
		rd(CTRL_OFS, d, r);
		chk_val(d, {16'h0, CTRL_RST});
		rd(8'h10, d, r);
		chk_resp(r, RESP_SLVERR);
	endtask : test_regs

	task automatic test_sequential;
		do_reset();
		slow <= 1'b1;
		wr(SCAN_OFS, 32'h0000_FFFF);
		wr(CTRL_OFS, 32'h0000_F223);
		for (int i = 0; i < 16; i++) begin
			wait_start();
			chk_val(32'(conv_channel), 32'(i % 4));
		end
		wait_done(16);
		chk_val(32'(overlap), 32'h1);
		wr(CTRL_OFS, 32'h0);
		for (int i = 0; i < 16; i++) begin
			rd(BUF_OFS + 8'(4 * i), d, r);
			chk_val(d, exp_res(i % 4, 1'((i / 4) % 2)));
		end
		slow <= 1'b0;
	endtask : test_sequential

	task automatic test_manual;
		logic bad;
		do_reset();
		wr(CTRL_OFS, 32'h0000_0021);
		wr(CTRL_OFS, 32'h0000_0025);
		wait_done(1);
		bad = 1'b0;
		repeat (60) begin
			@(negedge mclk);
			if (sh_sample !== 4'h0) bad = 1'b1;
		end
		chk_val(32'(bad), 32'h0);
		wr(CTRL_OFS, 32'h0000_0025);
		wait_start();
		chk_val(32'(sh_pos_input[0]), 32'h0);
		wait_done(2);
		rd(BUF_OFS, d, r);
		chk_val(d, exp_res(0, 1'b0));
	endtask : test_manual

	task automatic test_simultaneous;
		do_reset();
		wr(CTRL_OFS, 32'h0000_320B);
		do @(negedge mclk); while (sh_sample === 4'h0);
		chk_val(32'(sh_sample), 32'hF);
		for (int i = 0; i < 4; i++) begin
			wait_start();
			chk_val(32'(conv_channel), 32'(i));
		end
		wait_done(4);
		wr(CTRL_OFS, 32'h0);
		for (int i = 0; i < 4; i++) begin
			rd(BUF_OFS + 8'(4 * i), d, r);
			chk_val(d, exp_res(i, 1'b0));
		end
	endtask : test_simultaneous

	always @(posedge mclk) begin
		if (conv_done === 1'b1) n_done <= n_done + 1;
		cbusy <= reset ? 1'b0 : conv_start ? 1'b1 : conv_done ? 1'b0 : cbusy;
		prev_s <= sh_sample;
		// a held channel keeps its last sampling length until it samples again
		for (int c = 0; c < 4; c++)
			scnt[c] <= !sh_sample[c] ? scnt[c] : prev_s[c] ? scnt[c] + 10'h1 : 10'h1;
	end

	always @(negedge mclk) begin
		if (!reset && cbusy && (sh_sample & ~(4'h1 << conv_channel)) != 4'h0) overlap = 1'b1;
		if (!reset && conv_start === 1'b1)
			chk_val(32'(scnt[conv_channel] >= 10'(SAMPLE_CNT)), 32'h1);
	end

	initial begin
		#(40 * 30000);
		n_errors++;
		finish_test();
	end

	initial begin
		req = '0;
		reset = 1'b1;
		slow = 1'b0;
		n_done = 0;
		overlap = 1'b0;
		n_errors = 0;
		samples_checked = 0;
		do_reset();
		test_regs();
		test_sequential();
		test_manual();
		test_simultaneous();
		finish_test();
	end
endmodule : multi_channel_sample_convert_sequencer_tb
`default_nettype wire
